// *** design/gep_port.sv ***
// eight pin gpio port with edge/level events and notification routing
`timescale 1ns/1ps
module gep_port
    import gep_pkg::*;
#(
    parameter bit          EVENT_SUPPORT = 1'b1,
    parameter int unsigned DB_CYCLES     = DEBOUNCE_CYCLES
) (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        port_active_i,
    input  wire logic [3:0]  irq_select_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [2:0]  reg_addr_i,
    input  wire logic [2:0]  pin_sel_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic [7:0]  port_pin_n_i,
    output logic      [7:0]  port_pin_n_o,
    output logic      [7:0]  port_pin_n_oe_o,
    output logic      [7:0]  pull_up_en_o,
    output logic      [15:0] irq_lines_o,
    output logic             smi_o,
    output logic             power_up_request_o
);

    gep_req_t    req;
    gep_pad_t    next_pad;
    gep_notify_t next_notify;

    logic [7:0] pin_setup_reg [PIN_COUNT];
    logic [2:0] notify_route_reg [PIN_COUNT];
    logic [7:0] output_latch_reg;
    logic [7:0] event_enable_reg;
    logic [7:0] edge_status_reg;
    logic [7:0] pin_level_reg;
    logic [7:0] det_level;
    logic [7:0] det_prev;
    logic [7:0] active_edge;
    logic [7:0] pending;
    logic [7:0] next_rdata;
    logic [7:0] setup_mask;

    assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, pin_sel: pin_sel_i, wdata: reg_wdata_i};
    assign setup_mask = EVENT_SUPPORT ? RST_SETUP_MASK : LOCKED_MASK;

    // does this write hit the given offset
    function automatic logic hit(input gep_req_t r, input logic [2:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction

    // event enable and edge status are reachable only while active
    function automatic logic ev_access(input gep_req_t r, input logic [2:0] ofs, input logic act);
        return hit(r, ofs) && act;
    endfunction

    // pin setup registers, one per pin, reached through the pin select index
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                pin_setup_reg[i] <= RST_PIN_SETUP & setup_mask;
            end
        end else if (hit(req, OFS_PIN_SETUP)) begin
            if (pin_setup_reg[req.pin_sel][CFG_LOCK]) begin
                pin_setup_reg[req.pin_sel] <= ((pin_setup_reg[req.pin_sel] & LOCKED_MASK)
                                              | (req.wdata & ~LOCKED_MASK)) & setup_mask;
            end else begin
                pin_setup_reg[req.pin_sel] <= ((req.wdata & ~(8'h01 << CFG_LOCK))
                                              | ((req.wdata | pin_setup_reg[req.pin_sel])
                                                 & (8'h01 << CFG_LOCK))) & setup_mask;
            end
        end
    end

    // notification routing per pin
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                notify_route_reg[i] <= RST_NOTIFY_ROUTE;
            end
        end else if (hit(req, OFS_NOTIFY_ROUTE)) begin
            notify_route_reg[req.pin_sel] <= req.wdata[2:0];
        end
    end

    // output latch: locked pins keep their bit, inactive port blocks access
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            output_latch_reg <= RST_OUTPUT_LATCH;
        end else if (hit(req, OFS_OUTPUT_LATCH) && port_active_i) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (!pin_setup_reg[i][CFG_LOCK]) begin
                    output_latch_reg[i] <= req.wdata[i];
                end
            end
        end
    end

    // pin level sampling; inputs blocked while inactive
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pin_level_reg <= 8'hFF; // idle level under the pull-ups, matches the debouncer reset so no false edge
        end else if (port_active_i) begin
            pin_level_reg <= port_pin_n_i;
        end
    end

    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_db
            gep_debounce #(
                .DB_CYCLES (DB_CYCLES)
            ) u_db (
                .ref_clk_i (ref_clk_i),
                .resetn_i  (resetn_i),
                .enable_i  (pin_setup_reg[g][CFG_DEBOUNCE]),
                .level_i   (pin_level_reg[g]),
                .level_o   (det_level[g])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            det_prev <= 8'hFF;
        end else begin
            det_prev <= det_level;
        end
    end

    // active edge and pending per pin
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            active_edge[i] = pin_setup_reg[i][CFG_EV_POL] ? (det_level[i] & ~det_prev[i])
                                                            : (~det_level[i] & det_prev[i]);
            pending[i] = event_enable_reg[i]
                         & (pin_setup_reg[i][CFG_EV_LEVEL]
                            ? (det_level[i] == pin_setup_reg[i][CFG_EV_POL])
                            : edge_status_reg[i]);
        end
        if (!EVENT_SUPPORT) begin
            active_edge = 8'h00;
            pending     = 8'h00;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            event_enable_reg <= RST_EVENT_ENABLE;
        end else if (ev_access(req, OFS_EVENT_ENABLE, port_active_i)) begin
            event_enable_reg <= req.wdata;
        end
    end

    // edge status: set wins over the write-one clear
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            edge_status_reg <= RST_EDGE_STATUS;
        end else if (!port_active_i) begin
            edge_status_reg <= 8'h00;
        end else if (ev_access(req, OFS_EDGE_STATUS, port_active_i)) begin
            edge_status_reg <= (edge_status_reg & ~req.wdata) | active_edge;
        end else begin
            edge_status_reg <= edge_status_reg | active_edge;
        end
    end

    // pad drive
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            next_pad.oe[i]  = pin_setup_reg[i][CFG_OUT_EN]
                              & (pin_setup_reg[i][CFG_PUSH_PULL] | ~output_latch_reg[i]);
            next_pad.out[i] = output_latch_reg[i];
            next_pad.pull_up[i] = pin_setup_reg[i][CFG_PULL_UP];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            port_pin_n_o    <= 8'h00;
            port_pin_n_oe_o <= 8'h00;
            pull_up_en_o    <= 8'h00;
        end else begin
            port_pin_n_o    <= next_pad.out;
            port_pin_n_oe_o <= next_pad.oe;
            pull_up_en_o    <= next_pad.pull_up;
        end
    end

    // notification routing
    always_comb begin
        next_notify = '0;
        for (int i = 0; i < PIN_COUNT; i++) begin
            next_notify.irq              |= pending[i] & notify_route_reg[i][RT_IRQ];
            next_notify.smi              |= pending[i] & notify_route_reg[i][RT_SMI];
            next_notify.power_up_request |= pending[i] & notify_route_reg[i][RT_PWR];
        end
        if (!port_active_i) begin
            next_notify = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            irq_lines_o        <= 16'h0000;
            smi_o              <= 1'b0;
            power_up_request_o <= 1'b0;
        end else begin
            irq_lines_o        <= next_notify.irq ? (16'h0001 << irq_select_i) : 16'h0000;
            smi_o              <= next_notify.smi;
            power_up_request_o <= next_notify.power_up_request;
        end
    end

    // read data
    always_comb begin
        next_rdata = 8'h00;
        case (req.addr)
            OFS_OUTPUT_LATCH: next_rdata = port_active_i ? output_latch_reg : 8'h00;
            OFS_PIN_LEVEL:    next_rdata = port_active_i ? pin_level_reg : 8'h00;
            OFS_EVENT_ENABLE: next_rdata = port_active_i ? event_enable_reg : 8'h00;
            OFS_EDGE_STATUS:  next_rdata = port_active_i ? edge_status_reg : 8'h00;
            OFS_PIN_SETUP:    next_rdata = pin_setup_reg[req.pin_sel];
            OFS_NOTIFY_ROUTE: next_rdata = {5'h00, notify_route_reg[req.pin_sel]};
            default:          next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (req.rd) begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule // gep_port

// *** design/gep_pkg.sv ***
// package for the gpio event port: register map, field positions, reset values, timing
package gep_pkg;

    localparam int unsigned PIN_COUNT        = 8;

    // runtime register offsets (address port of the runtime space)
    localparam logic [2:0] OFS_OUTPUT_LATCH  = 3'h0;
    localparam logic [2:0] OFS_PIN_LEVEL     = 3'h1;
    localparam logic [2:0] OFS_EVENT_ENABLE  = 3'h2;
    localparam logic [2:0] OFS_EDGE_STATUS   = 3'h3;
    // configuration space: setup and route registers of the selected pin
    localparam logic [2:0] OFS_PIN_SETUP     = 3'h4;
    localparam logic [2:0] OFS_NOTIFY_ROUTE  = 3'h5;

    // pin setup field positions
    localparam int unsigned CFG_OUT_EN       = 0;
    localparam int unsigned CFG_PUSH_PULL    = 1;
    localparam int unsigned CFG_PULL_UP      = 2;
    localparam int unsigned CFG_LOCK         = 3;
    localparam int unsigned CFG_EV_LEVEL     = 4;
    localparam int unsigned CFG_EV_POL       = 5;
    localparam int unsigned CFG_DEBOUNCE     = 6;

    // notify route field positions
    localparam int unsigned RT_IRQ           = 0;
    localparam int unsigned RT_SMI           = 1;
    localparam int unsigned RT_PWR           = 2;

    // reset values
    localparam logic [7:0] RST_PIN_SETUP     = 8'h44;
    localparam logic [7:0] RST_SETUP_MASK    = 8'h7F;
    localparam logic [7:0] LOCKED_MASK       = 8'h0F;
    localparam logic [2:0] RST_NOTIFY_ROUTE  = 3'h0;
    localparam logic [7:0] RST_OUTPUT_LATCH  = 8'h00;
    localparam logic [7:0] RST_EVENT_ENABLE  = 8'h00;
    localparam logic [7:0] RST_EDGE_STATUS   = 8'h00;

    // debounce timing
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned DEBOUNCE_MS      = 15;
    localparam int unsigned DEBOUNCE_CYCLES  = (DEBOUNCE_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned DB_CNT_W         = 21;

    // register access request from the host bus
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [2:0] pin_sel;
        logic [7:0] wdata;
    } gep_req_t;

    // pin drive toward the pad
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull_up;
    } gep_pad_t;

    // notification outputs
    typedef struct packed {
        logic irq;
        logic smi;
        logic power_up_request;
    } gep_notify_t;

endpackage

// *** design/gep_debounce.sv ***
// one pin debouncer: passes the level after it has been stable for the debounce period
`timescale 1ns/1ps
module gep_debounce
    import gep_pkg::*;
#(
    parameter int unsigned DB_CYCLES = DEBOUNCE_CYCLES
) (
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic enable_i,
    input  wire logic level_i,
    output logic      level_o
);

    logic [DB_CNT_W-1:0] count;
    logic                last;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            last <= 1'b1;
        end else begin
            last <= level_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            count <= '0;
        end else if (level_i != last) begin
            count <= '0;
        end else if (count < DB_CNT_W'(DB_CYCLES)) begin
            count <= count + DB_CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            level_o <= 1'b1;
        end else if (!enable_i) begin
            level_o <= level_i;
        end else if (level_i == last && count >= DB_CNT_W'(DB_CYCLES - 1)) begin
            level_o <= level_i;
        end
    end

endmodule // gep_debounce

// *** verif/gep_port_monitor.sv ***
// assertion checker for the gpio event port, bound to its ports
`timescale 1ns/1ps
module gep_port_monitor
    import gep_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    input wire logic        port_active_i,
    input wire logic [3:0]  irq_select_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [2:0]  reg_addr_i,
    input wire logic [2:0]  pin_sel_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic [7:0]  port_pin_n_i,
    input wire logic [7:0]  port_pin_n_o,
    input wire logic [7:0]  port_pin_n_oe_o,
    input wire logic [7:0]  pull_up_en_o,
    input wire logic [15:0] irq_lines_o,
    input wire logic        smi_o,
    input wire logic        power_up_request_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    notify_off_a: assert property (!port_active_i |=> (irq_lines_o == 16'h0000 && !smi_o && !power_up_request_o))
        else $error("notification seen while port inactive");
    irq_onehot_a: assert property ($onehot0(irq_lines_o))
        else $error("more than one irq line asserted");
    irq_line_a: assert property ((|irq_lines_o && $stable(irq_select_i)) |-> irq_lines_o[irq_select_i])
        else $error("irq on a line other than the selected one");
    level_read_a: assert property (reg_rd_i && reg_addr_i == OFS_PIN_LEVEL && port_active_i && $past(port_active_i)
        && $past(resetn_i) |=> reg_rdata_o == $past(port_pin_n_i, 2))
        else $error("pin level read differs from the pad level");
    blocked_read_a: assert property (reg_rd_i && reg_addr_i <= OFS_EDGE_STATUS && !port_active_i |=> reg_rdata_o == 8'h00)
        else $error("runtime read not blocked while inactive");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
    latch_mirror_a: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == OFS_OUTPUT_LATCH && port_active_i
        |=> reg_rdata_o == port_pin_n_o)
        else $error("latch read differs from driven value");
    latch_blocked_a: assert property (reg_wr_i && reg_addr_i == OFS_OUTPUT_LATCH && !port_active_i ##1 !reg_wr_i
        |=> $stable(port_pin_n_o))
        else $error("latch write took effect while inactive");
    pins_frozen_a: assert property ((!port_active_i && !reg_wr_i)[*3] |-> $stable(port_pin_n_o) && $stable(port_pin_n_oe_o))
        else $error("pad outputs moved while inactive");
endmodule // gep_port_monitor

bind gep_port gep_port_monitor u_gep_port_monitor (.ref_clk_i, .resetn_i, .port_active_i, .irq_select_i, .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .pin_sel_i, .reg_wdata_i, .reg_rdata_o, .port_pin_n_i, .port_pin_n_o, .port_pin_n_oe_o,
    .pull_up_en_o, .irq_lines_o, .smi_o, .power_up_request_o);

// *** verif/gep_pin_world.sv ***
// pin partner: external drivers, pull-ups and floating pads resolved into pin levels
`timescale 1ns/1ps
module gep_pin_world
    import gep_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire gep_pad_t   pad_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic      [7:0] level_o
);
    logic [7:0] last;
    always_ff @(posedge ref_clk_i) last <= level_o;
    // a pad nobody holds or pulls shows the inverse of its last level
    always_comb
        for (int n = 0; n < 8; n++)
            level_o[n] = pad_i.oe[n] ? pad_i.out[n] : ext_en_i[n] ? ext_val_i[n] : pad_i.pull_up[n] ? 1'b1 : ~last[n];
endmodule // gep_pin_world

// *** verif/tb.sv ***
// self-checking bench for the gpio event port with a register model and pin partner
`timescale 1ns/1ps
module tb;
    import gep_pkg::*;
    localparam int unsigned DBC = 20;
    logic        ref_clk_i     = 1'b0;
    logic        resetn_i      = 1'b0;
    logic        port_active_i = 1'b1;
    logic [3:0]  irq_select_i  = 4'h5;
    gep_req_t    req           = '0;
    gep_pad_t    pad;
    logic [7:0]  reg_rdata_o, pin_lvl, d, m_latch, m_en;
    logic [7:0]  ext_en        = 8'h00;
    logic [7:0]  ext_val       = 8'h00;
    logic [7:0]  m_cfg [8];
    logic [15:0] irq_lines_o;
    logic        smi_o, pwr_o, p;
    int          err_count, comparisons, cyc, i, k, r;
    int          seed          = 32'hdbc8a159;

    gep_port #(.DB_CYCLES(DBC)) u_gep_port (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .port_active_i(port_active_i),
        .irq_select_i(irq_select_i), .reg_wr_i(req.wr), .reg_rd_i(req.rd), .reg_addr_i(req.addr),
        .pin_sel_i(req.pin_sel), .reg_wdata_i(req.wdata), .reg_rdata_o(reg_rdata_o), .port_pin_n_i(pin_lvl),
        .port_pin_n_o(pad.out), .port_pin_n_oe_o(pad.oe), .pull_up_en_o(pad.pull_up), .irq_lines_o(irq_lines_o),
        .smi_o(smi_o), .power_up_request_o(pwr_o));
    gep_pin_world u_gep_pin_world (.ref_clk_i(ref_clk_i), .pad_i(pad), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .level_o(pin_lvl));

    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic count(input logic ok);
        comparisons++;
        if (!ok) begin
            err_count++;
            $display("unexpected at %0t: value mismatch", $time);
        end
    endtask
    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e); count(g === e); endtask
    task automatic chk_bit(input logic g, input logic e); count(g === e); endtask

    task automatic wr(input logic [2:0] a, input logic [2:0] s, input logic [7:0] v);
        @(negedge ref_clk_i);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, pin_sel: s, wdata: v};
        @(negedge ref_clk_i);
        req.wr = 1'b0;
        if (a == OFS_PIN_SETUP)
            m_cfg[s] = m_cfg[s][CFG_LOCK] ? {1'b0, v[6:4], m_cfg[s][3:0]} : (v & RST_SETUP_MASK);
        for (int n = 0; n < 8; n++)
            if (a == OFS_OUTPUT_LATCH && port_active_i && !m_cfg[n][CFG_LOCK]) m_latch[n] = v[n];
        if (a == OFS_EVENT_ENABLE && port_active_i) m_en = v;
    endtask

    task automatic rd(input logic [2:0] a, input logic [2:0] s, input logic [7:0] e);
        @(negedge ref_clk_i);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, pin_sel: s, wdata: 8'h00};
        @(negedge ref_clk_i);
        req.rd = 1'b0;
        @(negedge ref_clk_i);
        chk_reg(reg_rdata_o, e);
    endtask

    function automatic logic note(input int t);
        return t == 0 ? irq_lines_o[irq_select_i] : t == 1 ? smi_o : pwr_o;
    endfunction

    task automatic wnote(input int t, input logic e, input int lim);
        int n;
        for (n = 0; n < lim && note(t) !== e; n++)
            @(negedge ref_clk_i);
        chk_bit(note(t), e);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        for (i = 0; i < 8; i++) m_cfg[i] = RST_PIN_SETUP;
        m_latch = 8'h00;
        m_en = 8'h00;
        repeat (2) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        for (i = 0; i < 8; i++) rd(OFS_PIN_SETUP, i[2:0], 8'h44);
        rd(OFS_NOTIFY_ROUTE, 3'h0, 8'h00);
        rd(OFS_EDGE_STATUS, 3'h0, 8'h00);
        rd(OFS_PIN_LEVEL, 3'h0, 8'hFF);
        chk_reg(pad.oe, 8'h00);
        chk_reg(pad.pull_up, 8'hFF);
        $display("test reset done");
        for (i = 0; i < 8; i++) wr(OFS_PIN_SETUP, i[2:0], i < 4 ? 8'h07 : 8'h05);
        repeat (3) begin
            d = 8'($random(seed));
            wr(OFS_OUTPUT_LATCH, 3'h0, d);
            rd(OFS_OUTPUT_LATCH, 3'h0, d);
            chk_reg(pad.oe, {~d[7:4], 4'hF});
            wr(OFS_PIN_LEVEL, 3'h0, ~d);
            rd(OFS_PIN_LEVEL, 3'h0, d);
        end
        $display("test drive done");
        wr(OFS_PIN_SETUP, 3'h7, 8'h0D);
        wr(OFS_PIN_SETUP, 3'h7, 8'h00);
        rd(OFS_PIN_SETUP, 3'h7, m_cfg[7]);
        wr(OFS_OUTPUT_LATCH, 3'h0, ~m_latch);
        rd(OFS_OUTPUT_LATCH, 3'h0, m_latch);
        $display("test lock done");
        for (k = 0; k < 6; k++) begin
            p = k[0];
            r = k / 2;
            wr(OFS_PIN_SETUP, 3'h0, {2'b00, p, 5'b00111});
            wr(OFS_OUTPUT_LATCH, 3'h0, {m_latch[7:1], ~p});
            wr(OFS_NOTIFY_ROUTE, 3'h0, 8'(1 << r));
            wr(OFS_EDGE_STATUS, 3'h0, 8'hFF);
            rd(OFS_EDGE_STATUS, 3'h0, 8'h00);
            wr(OFS_EVENT_ENABLE, 3'h0, 8'h01);
            wr(OFS_OUTPUT_LATCH, 3'h0, {m_latch[7:1], p});
            wnote(r, 1'b1, 12);
            wr(OFS_EDGE_STATUS, 3'h0, 8'h00);
            rd(OFS_EDGE_STATUS, 3'h0, 8'h01);
            wr(OFS_EDGE_STATUS, 3'h0, 8'h01);
            wnote(r, 1'b0, 6);
        end
        $display("test edge done");
        wr(OFS_PIN_SETUP, 3'h0, 8'h37);
        wr(OFS_NOTIFY_ROUTE, 3'h0, 8'h01);
        wnote(0, 1'b1, 12);
        wr(OFS_EDGE_STATUS, 3'h0, 8'hFF);
        repeat (5) @(negedge ref_clk_i);
        chk_bit(note(0), 1'b1);
        wr(OFS_EVENT_ENABLE, 3'h0, 8'h00);
        wnote(0, 1'b0, 6);
        $display("test level done");
        wr(OFS_PIN_SETUP, 3'h1, 8'h44);
        wr(OFS_NOTIFY_ROUTE, 3'h1, 8'h01);
        repeat (DBC + 10) @(negedge ref_clk_i);
        wr(OFS_EDGE_STATUS, 3'h0, 8'hFF);
        wr(OFS_EVENT_ENABLE, 3'h0, 8'h02);
        ext_en[1] = 1'b1;
        repeat (10) @(negedge ref_clk_i);
        ext_en[1] = 1'b0;
        repeat (DBC + 10) @(negedge ref_clk_i);
        rd(OFS_EDGE_STATUS, 3'h0, 8'h00);
        ext_en[1] = 1'b1;
        repeat (DBC - 5) @(negedge ref_clk_i);
        chk_bit(note(0), 1'b0);
        wnote(0, 1'b1, 20);
        $display("test debounce done");
        port_active_i = 1'b0;
        wnote(0, 1'b0, 4);
        rd(OFS_EDGE_STATUS, 3'h0, 8'h00);
        rd(OFS_OUTPUT_LATCH, 3'h0, 8'h00);
        wr(OFS_OUTPUT_LATCH, 3'h0, ~m_latch);
        port_active_i = 1'b1;
        rd(OFS_EDGE_STATUS, 3'h0, 8'h00);
        rd(OFS_OUTPUT_LATCH, 3'h0, m_latch);
        rd(OFS_EVENT_ENABLE, 3'h0, m_en);
        $display("test inactive done");
        report_and_stop();
    end
endmodule // tb
